// ==== design/pag_pkg.sv ====
// Package with widths, source selections and stack commands for the program address generator
package pag_pkg;
    localparam int ADDR_W = 16;
    localparam int STACK_DEPTH = 8;
    localparam int REPEAT_W = 16;
    localparam logic [ADDR_W-1:0] ADDR_RESET = 16'h0000;
    localparam logic [ADDR_W-1:0] STEP_ONE = 16'h0001;
    localparam logic [ADDR_W-1:0] STEP_TWO = 16'h0002;
    localparam logic [REPEAT_W-1:0] REPEAT_RESET = 16'h0000;
    localparam logic [REPEAT_W-1:0] REPEAT_ONE = 16'h0001;

    // Where the next fetch address comes from
    typedef enum logic [2:0] {
        PAG_SRC_SEQ,
        PAG_SRC_DUMMY,
        PAG_SRC_RETURN,
        PAG_SRC_MOVE_RET,
        PAG_SRC_IMMEDIATE,
        PAG_SRC_ACC,
        PAG_SRC_VECTOR
    } pag_src_t;

    // Stack operation requested by the instruction decoder
    typedef enum logic [2:0] {
        PAG_STK_NONE,
        PAG_STK_PUSH_ACC,
        PAG_STK_POP_ACC,
        PAG_STK_PUSH_MEM,
        PAG_STK_POP_MEM
    } pag_stk_op_t;
endpackage

// ==== design/pag_stack.sv ====
// Eight-level shifting hardware stack with no overflow or underflow indication
`timescale 1ns/1ps
`default_nettype none
module pag_stack #(
    parameter int WIDTH = pag_pkg::ADDR_W,
    parameter int DEPTH = pag_pkg::STACK_DEPTH
) (
    input wire logic i_mclk,
    input wire logic i_nrst,
    input wire logic i_push,
    input wire logic i_pop,
    input wire logic [WIDTH-1:0] i_push_data,
    output logic [WIDTH-1:0] o_stack_top
);
    import pag_pkg::*;

    logic [WIDTH-1:0] level [DEPTH];

    assign o_stack_top = level[0];

    // Push wins if both arrive; the decoder never asks for both at once
    genvar g;
    generate
        for (g = 0; g < DEPTH; g++)
        begin : g_level
            always_ff @(posedge i_mclk or negedge i_nrst)
            begin
                if (!i_nrst)
                    level[g] <= '0;
                else if (i_push)
                    level[g] <= (g == 0) ? i_push_data : level[(g == 0) ? 0 : g - 1]; // [RQ13] [RQ10]
                else if (i_pop && g < DEPTH - 1)
                    level[g] <= level[(g < DEPTH - 1) ? g + 1 : g]; // [RQ14] [RQ20]
            end
        end
    endgenerate
endmodule
`default_nettype wire

// ==== design/pag_move_slot.sv ====
// One-level return slot for repeated two-operand moves, unreachable by instructions
`timescale 1ns/1ps
`default_nettype none
module pag_move_slot #(
    parameter int WIDTH = pag_pkg::ADDR_W
) (
    input wire logic i_mclk,
    input wire logic i_nrst,
    input wire logic i_save,
    input wire logic [WIDTH-1:0] i_save_addr,
    output logic [WIDTH-1:0] o_move_return_slot
);
    import pag_pkg::*;

    // Only the address logic writes it, so no port exists for software [RQ17]
    always_ff @(posedge i_mclk or negedge i_nrst)
    begin
        if (!i_nrst)
            o_move_return_slot <= '0;
        else if (i_save)
            o_move_return_slot <= i_save_addr; // [RQ15]
    end
endmodule
`default_nettype wire

// ==== design/pag_top.sv ====
// Program address generator: counter, fetch latch, stack, move slot and repeat counter
// Notes on behaviour
// RQ1 - Sequential step adds one or two words
// RQ2 - Dummy cycle refetches from the fetch latch
// RQ3 - Return loads counter from stack top
// RQ4 - Move end resumes from the move slot
// RQ5 - Direct branch takes immediate from program bus
// RQ6 - Computed jump takes low accumulator word
// RQ7 - Interrupt loads the vector location
// RQ8 - Call pushes return address, then loads target
// RQ9 - Sixteen-bit counter; latch drives address bus
// RQ10 - Stack is 16 by 8, free push
// RQ11 - Accumulator push and pop use stack top
// RQ12 - Memory push and pop use stack top
// RQ13 - Push shifts down, bottom level lost
// RQ14 - Pop shifts up, bottom level kept
// RQ15 - Move instructions save next address first
// RQ16 - Repeated moves step operand via counter; counter steps on from the return point, i_move_operand_addr unused
// RQ17 - Slot restored at end, no instruction access
// RQ18 - Repeat counter loaded by repeat instruction
// RQ19 - Counter holds next address after fetch
// RQ20 - No overflow or underflow flag
`timescale 1ns/1ps
`default_nettype none
module pag_top #(
    parameter int ADDR_W = pag_pkg::ADDR_W,
    parameter int REPEAT_W = pag_pkg::REPEAT_W
) (
    input wire logic i_mclk,
    input wire logic i_nrst,
    input wire logic i_advance,
    input wire logic i_two_word,
    input wire pag_pkg::pag_src_t i_src,
    input wire logic i_call,
    input wire logic [ADDR_W-1:0] i_program_read_bus,
    input wire logic [ADDR_W-1:0] i_data_read_bus,
    input wire logic [ADDR_W-1:0] i_vector_addr,
    input wire pag_pkg::pag_stk_op_t i_stack_op,
    input wire logic i_move_start,
    input wire logic [ADDR_W-1:0] i_move_operand_addr,
    input wire logic i_repeat_load,
    input wire logic [REPEAT_W-1:0] i_repeat_count,
    input wire logic i_repeat_step,
    output logic [ADDR_W-1:0] o_program_addr_bus,
    output logic [ADDR_W-1:0] o_prog_counter,
    output logic [ADDR_W-1:0] o_stack_top,
    output logic [ADDR_W-1:0] o_stack_pop_data,
    output logic o_stack_pop_valid,
    output logic [REPEAT_W-1:0] o_repeat_counter,
    output logic o_repeat_active,
    output logic o_move_active
);
    import pag_pkg::*;

    logic [ADDR_W-1:0] prog_counter;
    logic [ADDR_W-1:0] fetch_address_latch;
    logic [ADDR_W-1:0] next_fetch;
    logic [ADDR_W-1:0] step;
    logic [ADDR_W-1:0] push_data;
    logic [ADDR_W-1:0] stack_top;
    logic [ADDR_W-1:0] move_return_slot;
    logic [REPEAT_W-1:0] repeat_counter;
    logic stack_push;
    logic stack_pop;
    logic move_active;
    logic move_end;

    assign step = i_two_word ? STEP_TWO : STEP_ONE; // [RQ1]

    // Source selection for the address that the fetch latch puts on the program bus after the next clock edge
    always_comb
    begin
        case (i_src)
            PAG_SRC_SEQ: next_fetch = prog_counter; // [RQ1]
            PAG_SRC_DUMMY: next_fetch = fetch_address_latch; // [RQ2]
            PAG_SRC_RETURN: next_fetch = stack_top; // [RQ3]
            PAG_SRC_MOVE_RET: next_fetch = move_return_slot; // [RQ4] [RQ17]
            PAG_SRC_IMMEDIATE: next_fetch = i_program_read_bus; // [RQ5]
            PAG_SRC_ACC: next_fetch = i_data_read_bus; // [RQ6]
            PAG_SRC_VECTOR: next_fetch = i_vector_addr; // [RQ7]
            default: next_fetch = prog_counter;
        endcase
    end

    // Call pushes the return address, which is the counter before the target load [RQ8]
    always_comb
    begin
        stack_push = 1'b0;
        stack_pop = 1'b0;
        push_data = prog_counter;
        if (i_advance && (i_call || i_src == PAG_SRC_VECTOR))
        begin
            stack_push = 1'b1; // [RQ8] [RQ10]
            push_data = prog_counter;
        end
        else if (i_advance && i_src == PAG_SRC_RETURN)
            stack_pop = 1'b1; // [RQ3]
        else
        begin
            case (i_stack_op)
                PAG_STK_PUSH_ACC:
                begin
                    stack_push = 1'b1;
                    push_data = i_data_read_bus; // [RQ11]
                end
                PAG_STK_PUSH_MEM:
                begin
                    stack_push = 1'b1;
                    push_data = i_data_read_bus; // [RQ12]
                end
                PAG_STK_POP_ACC: stack_pop = 1'b1; // [RQ11]
                PAG_STK_POP_MEM: stack_pop = 1'b1; // [RQ12]
                default:
                begin
                    stack_push = 1'b0;
                    stack_pop = 1'b0;
                end
            endcase
        end
    end

    // Latch holds the address now on the bus, so a dummy cycle repeats it
    always_ff @(posedge i_mclk or negedge i_nrst)
    begin
        if (!i_nrst)
            fetch_address_latch <= ADDR_RESET;
        else if (i_advance)
            fetch_address_latch <= next_fetch; // [RQ9]
    end

    // Counter runs one fetch ahead so it already names the following word
    always_ff @(posedge i_mclk or negedge i_nrst)
    begin
        if (!i_nrst)
            prog_counter <= ADDR_RESET;
        else if (i_advance && i_src != PAG_SRC_DUMMY)
            prog_counter <= next_fetch + step; // [RQ19] [RQ1]
        else if (move_active && i_repeat_step)
            prog_counter <= prog_counter + STEP_ONE; // [RQ16]
    end

    // Move start saves the counter as the return point; the operand address is never loaded into the counter
    assign move_end = move_active && repeat_counter == REPEAT_RESET && !i_repeat_step;

    always_ff @(posedge i_mclk or negedge i_nrst)
    begin
        if (!i_nrst)
            move_active <= 1'b0;
        else if (i_move_start)
            move_active <= 1'b1; // [RQ15]
        else if (i_advance && i_src == PAG_SRC_MOVE_RET)
            move_active <= 1'b0; // [RQ4]
    end

    always_ff @(posedge i_mclk or negedge i_nrst)
    begin
        if (!i_nrst)
            repeat_counter <= REPEAT_RESET;
        else if (i_repeat_load)
            repeat_counter <= i_repeat_count; // [RQ18]
        else if (i_repeat_step && repeat_counter != REPEAT_RESET)
            repeat_counter <= repeat_counter - REPEAT_ONE; // [RQ18]
    end

    // Pop data is registered so the accumulator or memory side sees a stable word
    always_ff @(posedge i_mclk or negedge i_nrst)
    begin
        if (!i_nrst)
        begin
            o_stack_pop_data <= ADDR_RESET;
            o_stack_pop_valid <= 1'b0;
        end
        else
        begin
            o_stack_pop_valid <= stack_pop && i_stack_op != PAG_STK_NONE;
            if (stack_pop)
                o_stack_pop_data <= stack_top; // [RQ11] [RQ12]
        end
    end

    pag_stack #(
        .WIDTH(ADDR_W),
        .DEPTH(STACK_DEPTH)
    ) u_stack (
        .i_mclk(i_mclk),
        .i_nrst(i_nrst),
        .i_push(stack_push),
        .i_pop(stack_pop),
        .i_push_data(push_data),
        .o_stack_top(stack_top)
    );

    pag_move_slot #(
        .WIDTH(ADDR_W)
    ) u_move_slot (
        .i_mclk(i_mclk),
        .i_nrst(i_nrst),
        .i_save(i_move_start),
        .i_save_addr(prog_counter), // [RQ15]
        .o_move_return_slot(move_return_slot)
    );

    assign o_program_addr_bus = fetch_address_latch; // [RQ9]
    assign o_prog_counter = prog_counter;
    assign o_stack_top = stack_top;
    assign o_repeat_counter = repeat_counter;
    assign o_repeat_active = repeat_counter != REPEAT_RESET;
    assign o_move_active = move_active && !move_end;
endmodule
`default_nettype wire

// ==== dv/pag_prog_mem.sv ====
// Program memory model answering fetches with an address-derived word
`timescale 1ns/1ps
`default_nettype none
module pag_prog_mem (
    input wire logic [15:0] i_addr,
    output logic [15:0] o_word
);
    // Word differs from its address so a wrong source cannot pass unnoticed
    assign o_word = {i_addr[7:0], ~i_addr[15:8]};
endmodule
`default_nettype wire

// ==== dv/pag_props.sv ====
// Assertions on the program address generator ports
`timescale 1ns/1ps
`default_nettype none
module pag_props (
    input wire logic i_mclk,
    input wire logic i_nrst,
    input wire logic i_advance,
    input wire logic i_two_word,
    input wire pag_pkg::pag_src_t i_src,
    input wire logic i_call,
    input wire logic [15:0] i_program_read_bus,
    input wire logic [15:0] i_data_read_bus,
    input wire logic [15:0] i_vector_addr,
    input wire pag_pkg::pag_stk_op_t i_stack_op,
    input wire logic i_repeat_load,
    input wire logic [15:0] i_repeat_count,
    input wire logic [15:0] o_program_addr_bus,
    input wire logic [15:0] o_prog_counter,
    input wire logic [15:0] o_stack_top,
    input wire logic [15:0] o_repeat_counter
);
    import pag_pkg::*;
    default clocking @(posedge i_mclk); endclocking
    default disable iff (!i_nrst);
    sequence s_fetch(pag_src_t s);
        i_advance && i_src == s;
    endsequence
    property p_seq; s_fetch(PAG_SRC_SEQ) |=> o_program_addr_bus == $past(o_prog_counter)
        && o_prog_counter == $past(o_prog_counter) + ($past(i_two_word) ? 16'h0002 : 16'h0001); endproperty
    a_seq: assert property (p_seq) else $error("sequential step wrong");
    property p_dummy; s_fetch(PAG_SRC_DUMMY) |=> $stable(o_program_addr_bus) && $stable(o_prog_counter); endproperty
    a_dummy: assert property (p_dummy) else $error("dummy refetch wrong");
    property p_ret; s_fetch(PAG_SRC_RETURN) |=> o_program_addr_bus == $past(o_stack_top); endproperty
    a_ret: assert property (p_ret) else $error("return address wrong");
    property p_imm; s_fetch(PAG_SRC_IMMEDIATE) |=> o_program_addr_bus == $past(i_program_read_bus); endproperty
    a_imm: assert property (p_imm) else $error("immediate target wrong");
    property p_vec; s_fetch(PAG_SRC_VECTOR) |=> o_program_addr_bus == $past(i_vector_addr); endproperty
    a_vec: assert property (p_vec) else $error("vector address wrong");
    property p_call; i_advance && i_call |=> o_stack_top == $past(o_prog_counter); endproperty
    a_call: assert property (p_call) else $error("call return address wrong");
    property p_push; !i_advance && (i_stack_op == PAG_STK_PUSH_ACC || i_stack_op == PAG_STK_PUSH_MEM)
        |=> o_stack_top == $past(i_data_read_bus); endproperty
    a_push: assert property (p_push) else $error("stack push wrong");
    property p_rpt; i_repeat_load |=> o_repeat_counter == $past(i_repeat_count); endproperty
    a_rpt: assert property (p_rpt) else $error("repeat load wrong");
endmodule
bind pag_top pag_props u_props (.*);
`default_nettype wire

// ==== dv/testbench.sv ====
// Randomised bench with a reference model of the address generator
`timescale 1ns/1ps
`default_nettype none
module testbench;
    import pag_pkg::*;
    logic i_mclk = '0, i_nrst = '0, i_advance = '0, i_two_word = '0, i_call = '0, i_move_start = '0;
    logic i_repeat_load = '0, i_repeat_step = '0, o_stack_pop_valid, o_repeat_active, o_move_active;
    pag_src_t i_src = PAG_SRC_SEQ;
    pag_stk_op_t i_stack_op = PAG_STK_NONE;
    logic [15:0] i_data_read_bus = '0, i_vector_addr = '0, i_repeat_count = '0, i_move_operand_addr = '0;
    logic [15:0] o_program_addr_bus, o_prog_counter, o_stack_top, o_stack_pop_data, o_repeat_counter;
    wire logic [15:0] i_program_read_bus;
    logic [15:0] pc = '0, lat = '0, slot = '0, rc = '0, pd = '0, sel;
    logic [15:0] stk [8] = '{default: '0};
    logic pv = '0, mv = '0;
    int error_cnt = 0, compares = 0, n;
    pag_top u_dut (.*);
    pag_prog_mem u_mem (.i_addr(o_program_addr_bus), .o_word(i_program_read_bus));
    task automatic check(input string nm, input logic [15:0] seen, input logic [15:0] exp);
        compares++;
        if (seen !== exp)
        begin
            error_cnt++;
            $display("[FAIL] %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    task automatic push(input logic [15:0] d);
        for (int i = 7; i > 0; i--) stk[i] = stk[i - 1];
        stk[0] = d;
    endtask
    task automatic model();
        pv = '0;
        if (i_advance)
        begin
            case (i_src)
                PAG_SRC_SEQ: sel = pc;
                PAG_SRC_DUMMY: sel = lat;
                PAG_SRC_RETURN: sel = stk[0];
                PAG_SRC_MOVE_RET: sel = slot;
                PAG_SRC_IMMEDIATE: sel = {lat[7:0], ~lat[15:8]};
                PAG_SRC_ACC: sel = i_data_read_bus;
                default: sel = i_vector_addr;
            endcase
            if (i_call || i_src == PAG_SRC_VECTOR) push(pc);
            if (i_src == PAG_SRC_RETURN)
                for (int i = 0; i < 7; i++) stk[i] = stk[i + 1];
            if (i_src == PAG_SRC_MOVE_RET) mv = '0;
            if (i_src != PAG_SRC_DUMMY) pc = sel + (i_two_word ? 16'h0002 : 16'h0001);
            lat = sel;
        end
        else
        begin
            if (i_stack_op == PAG_STK_PUSH_ACC || i_stack_op == PAG_STK_PUSH_MEM) push(i_data_read_bus);
            if (i_stack_op == PAG_STK_POP_ACC || i_stack_op == PAG_STK_POP_MEM)
            begin
                pd = stk[0];
                pv = '1;
                // Bottom level is copied up, never cleared
                for (int i = 0; i < 7; i++) stk[i] = stk[i + 1];
            end
            if (i_move_start)
            begin
                slot = pc;
                mv = '1;
            end
            if (i_repeat_step && mv) pc = pc + 16'h0001;
        end
        if (i_repeat_load) rc = i_repeat_count;
        else if (i_repeat_step && rc != 0) rc = rc - 16'h0001;
    endtask
    task automatic drive();
        logic [31:0] r;
        r = $urandom;
        // First twenty cycles: ten pushes then ten pops to overrun both stack ends
        i_advance = n >= 20 && r[0];
        i_two_word = r[1];
        i_src = pag_src_t'($urandom_range(6));
        i_call = i_advance && r[2] && (i_src == PAG_SRC_IMMEDIATE || i_src == PAG_SRC_ACC);
        i_stack_op = i_advance ? PAG_STK_NONE : pag_stk_op_t'(n < 20 ? (n < 10 ? 1 : 4) : $urandom_range(4));
        i_move_start = !i_advance && r[3] && r[4];
        i_repeat_load = r[5] && r[6];
        i_repeat_step = !i_advance && !i_move_start && !i_repeat_load && r[7] && rc != 0;
        i_data_read_bus = 16'($urandom);
        i_vector_addr = 16'($urandom);
        i_repeat_count = 16'($urandom_range(3));
    endtask
    task automatic complete_run();
        $display("compares %0d errors %0d", compares, error_cnt);
        if (error_cnt == 0 && compares > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask
    initial
    begin
        forever #4 i_mclk = ~i_mclk;
    end
    initial
    begin
        #25000;
        error_cnt++;
        complete_run();
    end
    initial
    begin
        void'($urandom(32'h6F1C));
        repeat (3) @(posedge i_mclk);
        #1 i_nrst = '1;
        for (n = 0; n < 600; n++)
        begin
            drive();
            @(posedge i_mclk);
            #1;
            model();
            check("bus", o_program_addr_bus, lat);
            check("pc", o_prog_counter, pc);
            check("top", o_stack_top, stk[0]);
            check("popv", 16'(o_stack_pop_valid), 16'(pv));
            if (pv) check("pop", o_stack_pop_data, pd);
            check("rpt", o_repeat_counter, rc);
            // Move stays visible until the repeat count runs out with no step pending
            check("mv", 16'(o_move_active), 16'(mv && (rc != 16'h0000 || i_repeat_step)));
            check("rpta", 16'(o_repeat_active), 16'(rc != 16'h0000));
        end
        complete_run();
    end
endmodule
`default_nettype wire
